// ---- logic/spi_master_slave_port.sv ----
// byte-wide serial port core with master and slave modes
//
// The plain strobed port and the register addresses are this design's own decisions.
`include "spi_port_cfg.svh"

// Contract
// - master write to txrx_buffer with the collision flag clear starts the byte at once.
// - bytes shift in and load the buffer only while the output is driven.
// - idle polarity and edge select fix clock level and change edge.
// - master rate: clock over 4, 16, 64, timer half, reload formula.
// - with edge select set, output is valid before first clock edge.
// - slave shifts only on external clock edges, flags last bit.
// - slave shifts during sleep and raises wake after eight bits.
// - overwrite enable lets slave writes pass an unread buffer.
// - mode 0100 selects slave with slave select control.
// - select low in that mode enables transfer and drives output.
// - select high releases the output at once, even mid byte.
// - select high or port disabled resets the bit counter to zero.
// - master sleep freezes the transfer; it resumes on wake.
// - eight bits move into the buffer, set full and done flags.
// - buffer write while busy is dropped and sets collision flag.
// - reading the buffer clears the full flag.
// - shift is msb first, new bit enters at lsb.
module spi_master_slave_port
  import spi_port_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic [`SPI_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // system
  input wire logic sleepMode,
  input wire logic periodTick,
  output logic wakeReq,
  // serial pins
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic sdiIn,
  output logic sdoOut,
  output logic sdoOe,
  input wire logic slaveSelN
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  ctrl_one_t ctrlOne_ff;
  logic smp_ff, cke_ff, bf_ff, overwrite_enable_bit_ff, wakeFlag_ff, wakeEn_ff;
  logic [7:0] buffer_ff, reload_ff, shift_ff;
  logic [3:0] bitCnt_ff;
  logic busy_ff, halfPhase_ff, prevSck_ff;
  logic [7:0] readMux, nxtShift;
  pins_in_t pinsSync;
  mode_t mode;
  logic isMaster, isSlave, selCtl, portHold, slaveGate;
  logic sckAct, prevAct, leadEdge, trailEdge, halfTick;
  logic sampleEv, changeEv, byteDone, masterEnd, busyNow;
  logic bufWr, bufRd, collision, load;

  assign mode = mode_t'(ctrlOne_ff.modeSelect);

  // ---------------------------------------------------------------
  // pin synchroniser and rate generator
  // ---------------------------------------------------------------
  spi_pin_sync #(.WIDTH(3)) pinSync (
    .ref_clk(ref_clk),
    .reset(reset),
    .asyncIn({sckIn, sdiIn, slaveSelN}),
    .syncOut(pinsSync)
  );

  spi_rate_gen #(.DIV_W(10)) rateGen (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(!busy_ff),
    .advance(busy_ff && isMaster && !sleepMode),
    .mode(mode),
    .reloadValue(reload_ff),
    .periodTick(periodTick),
    .halfTick(halfTick)
  );

  // ---------------------------------------------------------------
  // mode decode and events
  // ---------------------------------------------------------------
  assign isMaster = ctrlOne_ff.portEnable && (mode == MODE_M_DIV4 ||
    mode == MODE_M_DIV16 || mode == MODE_M_DIV64 ||
    mode == MODE_M_TIMER || mode == MODE_M_RELOAD);
  assign isSlave = ctrlOne_ff.portEnable &&
    (mode == MODE_S_SELECT || mode == MODE_S_FREE);
  assign selCtl = (mode == MODE_S_SELECT);
  assign portHold = !ctrlOne_ff.portEnable ||
    (isSlave && selCtl && pinsSync.slaveSelN);
  assign slaveGate = isSlave && !portHold;

  assign sckAct = pinsSync.sck ^ ctrlOne_ff.idlePolarity;
  assign prevAct = prevSck_ff ^ ctrlOne_ff.idlePolarity;
  assign leadEdge = sckAct && !prevAct;
  assign trailEdge = !sckAct && prevAct;

  always_comb
  begin
    if (isMaster)
    begin
      sampleEv = halfTick && (smp_ff ? halfPhase_ff : !halfPhase_ff);
      changeEv = halfTick && halfPhase_ff;
    end
    else
    begin
      sampleEv = slaveGate && (cke_ff ? leadEdge : trailEdge);
      changeEv = slaveGate && (cke_ff ? trailEdge : leadEdge);
    end
  end

  assign nxtShift = {shift_ff[6:0], pinsSync.sdi};
  assign byteDone = sampleEv && (bitCnt_ff == `BYTE_LAST_BIT);
  assign masterEnd = isMaster && changeEv &&
    (byteDone || bitCnt_ff == `BYTE_BITS);
  assign busyNow = isMaster ? busy_ff : (bitCnt_ff != 4'h0);

  assign bufWr = regWr && (regAddr == `REG_BUFFER);
  assign bufRd = regRd && (regAddr == `REG_BUFFER);
  assign collision = bufWr && busyNow;
  assign load = bufWr && !busyNow && !ctrlOne_ff.writeCollision &&
    ctrlOne_ff.portEnable && !(isSlave && bf_ff && !overwrite_enable_bit_ff);

  // ---------------------------------------------------------------
  // shift engine
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      shift_ff <= `RST_BYTE;
      bitCnt_ff <= 4'h0;
      busy_ff <= 1'h0;
      halfPhase_ff <= 1'h0;
    end
    else if (load)
    begin
      shift_ff <= regWdata;
      bitCnt_ff <= 4'h0;
      busy_ff <= isMaster;
      halfPhase_ff <= 1'h0;
    end
    else if (portHold)
    begin
      bitCnt_ff <= 4'h0;
      busy_ff <= 1'h0;
      halfPhase_ff <= 1'h0;
    end
    else
    begin
      if (sampleEv)
        shift_ff <= nxtShift;
      if (masterEnd || (isSlave && byteDone))
        bitCnt_ff <= 4'h0;
      else if (sampleEv)
        bitCnt_ff <= bitCnt_ff + 4'h1;
      if (masterEnd)
        busy_ff <= 1'h0;
      if (halfTick)
        halfPhase_ff <= !halfPhase_ff;
    end
  end

  // ---------------------------------------------------------------
  // serial outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sdoOut <= 1'h0;
      sdoOe <= 1'h0;
      prevSck_ff <= 1'h0;
    end
    else
    begin
      prevSck_ff <= pinsSync.sck;
      if (load)
        sdoOut <= regWdata[7];
      else if (changeEv)
        sdoOut <= sampleEv ? nxtShift[7] : shift_ff[7];
      sdoOe <= isMaster || slaveGate;
    end
  end

  // clock level from polarity and edge select
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sckOut <= 1'h0;
      sckOe <= 1'h0;
    end
    else
    begin
      sckOe <= isMaster;
      if (load && isMaster)
        sckOut <= ctrlOne_ff.idlePolarity ^ !cke_ff;
      else if (!busy_ff || masterEnd || portHold)
        sckOut <= ctrlOne_ff.idlePolarity;
      else if (halfTick)
        sckOut <= ctrlOne_ff.idlePolarity ^ (cke_ff ^ halfPhase_ff);
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      ctrlOne_ff <= ctrl_one_t'(`RST_BYTE);
      smp_ff <= 1'h0;
      cke_ff <= 1'h0;
      overwrite_enable_bit_ff <= 1'h0;
      reload_ff <= `RST_BYTE;
      wakeEn_ff <= 1'h0;
    end
    else
    begin
      if (regWr && regAddr == `REG_CTRL_ONE)
        ctrlOne_ff <= ctrl_one_t'(regWdata);
      if (collision)
        ctrlOne_ff.writeCollision <= 1'h1;
      if (byteDone && bf_ff)
        ctrlOne_ff.overflow <= 1'h1;
      if (regWr && regAddr == `REG_STATUS)
      begin
        smp_ff <= regWdata[`STAT_SMP];
        cke_ff <= regWdata[`STAT_CKE];
      end
      if (regWr && regAddr == `REG_CTRL_THREE)
        overwrite_enable_bit_ff <= regWdata[`CTRL3_OVERWRITE_ENABLE_BIT];
      if (regWr && regAddr == `REG_RELOAD)
        reload_ff <= regWdata;
      if (regWr && regAddr == `REG_WAKE)
        wakeEn_ff <= regWdata[`WAKE_EN];
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      buffer_ff <= `RST_BYTE;
      bf_ff <= 1'h0;
      wakeFlag_ff <= 1'h0;
      wakeReq <= 1'h0;
    end
    else
    begin
      if (byteDone)
        buffer_ff <= nxtShift;
      else if (load)
        buffer_ff <= regWdata;
      if (byteDone)
        bf_ff <= 1'h1;
      else if (bufRd)
        bf_ff <= 1'h0;
      if (byteDone)
        wakeFlag_ff <= 1'h1;
      else if (regWr && regAddr == `REG_WAKE)
        wakeFlag_ff <= regWdata[`WAKE_FLAG];
      wakeReq <= wakeFlag_ff && wakeEn_ff;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb
  begin
    readMux = 8'h00;
    if (regAddr == `REG_BUFFER)
      readMux = buffer_ff;
    else if (regAddr == `REG_CTRL_ONE)
      readMux = ctrlOne_ff;
    else if (regAddr == `REG_STATUS)
      readMux = {smp_ff, cke_ff, 5'h00, bf_ff};
    else if (regAddr == `REG_CTRL_THREE)
      readMux = {3'h0, overwrite_enable_bit_ff, 4'h0};
    else if (regAddr == `REG_RELOAD)
      readMux = reload_ff;
    else if (regAddr == `REG_WAKE)
      readMux = {6'h00, wakeEn_ff, wakeFlag_ff};
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      regRdata <= 8'h00;
    else
      regRdata <= regRd ? readMux : 8'h00;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_started;
    busy_ff && bitCnt_ff == 4'h0;
  endsequence
  sequence s_first_bit(logic b);
    sdoOut == b;
  endsequence

  property p_master_start;
    (load && isMaster && !portHold) |=>
      s_started and s_first_bit($past(regWdata[7]));
  endproperty
  a_master_start: assert property (p_master_start)
    else $error("master write did not start transfer");

  property p_idle_clock;
    (isMaster && !busy_ff && !load) |=> sckOut == $past(ctrlOne_ff.idlePolarity);
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("idle clock level wrong");

  property p_div4_rate;
    (halfTick && mode == MODE_M_DIV4 && !sleepMode) |=> !halfTick;
  endproperty
  a_div4_rate: assert property (p_div4_rate)
    else $error("divide by four half period too short");

  property p_sleep_freeze;
    (sleepMode && isMaster && busy_ff && !regWr) |=>
      $stable(shift_ff) && $stable(bitCnt_ff);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze)
    else $error("master transfer moved during sleep");

  property p_deselect_release;
    (isSlave && selCtl && pinsSync.slaveSelN) |=> !sdoOe;
  endproperty
  a_deselect_release: assert property (p_deselect_release)
    else $error("output still driven after deselect");

  property p_disable_count;
    !ctrlOne_ff.portEnable |=> bitCnt_ff == 4'h0 && !busy_ff;
  endproperty
  a_disable_count: assert property (p_disable_count)
    else $error("bit counter not cleared");

  property p_byte_to_buffer;
    byteDone && !portHold |=> bf_ff && buffer_ff == $past(nxtShift);
  endproperty
  a_byte_to_buffer: assert property (p_byte_to_buffer)
    else $error("completed byte not buffered");

  property p_collision;
    collision |=> ctrlOne_ff.writeCollision && $stable(busy_ff) [*1];
  endproperty
  a_collision: assert property (p_collision)
    else $error("collision not flagged");

  property p_read_clear;
    (bufRd && !byteDone) |=> !bf_ff;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("buffer read did not clear full flag");

endmodule : spi_master_slave_port

// ---- logic/spi_pin_sync.sv ----
// two flip-flop synchroniser for asynchronous pin inputs
module spi_pin_sync
  import spi_port_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // pins
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stageOne_ff;

  // ---------------------------------------------------------------
  // two stages
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      stageOne_ff <= '0;
      syncOut <= '0;
    end
    else
    begin
      stageOne_ff <= asyncIn;
      syncOut <= stageOne_ff;
    end
  end

endmodule : spi_pin_sync

// ---- logic/spi_port_cfg.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define SPI_ADDR_W 3
`define REG_BUFFER 3'h0
`define REG_CTRL_ONE 3'h1
`define REG_STATUS 3'h2
`define REG_CTRL_THREE 3'h3
`define REG_RELOAD 3'h4
`define REG_WAKE 3'h5

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define STAT_SMP 7
`define STAT_CKE 6
`define STAT_BF 0
`define CTRL3_OVERWRITE_ENABLE_BIT 4
`define WAKE_FLAG 0
`define WAKE_EN 1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_BYTE 8'h00

// ---------------------------------------------------------------
// timing: half serial clock period in ref_clk cycles, and bit counts per byte
// ---------------------------------------------------------------
`define HALF_DIV4 10'h002
`define HALF_DIV16 10'h008
`define HALF_DIV64 10'h020
`define BYTE_LAST_BIT 4'h7
`define BYTE_BITS 4'h8

`endif

// ---- logic/spi_port_pkg.sv ----
// types shared by the serial port design
package spi_port_pkg;

  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_M_DIV4 = 4'b0000,
    MODE_M_DIV16 = 4'b0001,
    MODE_M_DIV64 = 4'b0010,
    MODE_M_TIMER = 4'b0011,
    MODE_S_SELECT = 4'b0100,
    MODE_S_FREE = 4'b0101,
    MODE_M_RELOAD = 4'b1010
  } mode_t;

  // ---------------------------------------------------------------
  // control register one layout
  // ---------------------------------------------------------------
  typedef struct packed {
    logic writeCollision;
    logic overflow;
    logic portEnable;
    logic idlePolarity;
    logic [3:0] modeSelect;
  } ctrl_one_t;

  // ---------------------------------------------------------------
  // serial pins as seen by the core
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sck;
    logic sdi;
    logic slaveSelN;
  } pins_in_t;

endpackage : spi_port_pkg

// ---- logic/spi_rate_gen.sv ----
// master bit rate generator: one pulse per half serial clock period
`include "spi_port_cfg.svh"
module spi_rate_gen
  import spi_port_pkg::*;
#(
  parameter int DIV_W = 10
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // control
  input wire logic clear,
  input wire logic advance,
  input wire mode_t mode,
  input wire logic [7:0] reloadValue,
  input wire logic periodTick,
  // output
  output logic halfTick
);

  logic [DIV_W-1:0] count_ff;
  logic [DIV_W-1:0] halfLen;
  logic countEnd;

  // ---------------------------------------------------------------
  // divider length
  // ---------------------------------------------------------------
  always_comb
  begin
    case (mode)
      MODE_M_DIV16: halfLen = DIV_W'(`HALF_DIV16);
      MODE_M_DIV64: halfLen = DIV_W'(`HALF_DIV64);
      MODE_M_RELOAD: halfLen = DIV_W'({2'h0, reloadValue} + 10'h001) << 1;
      default: halfLen = DIV_W'(`HALF_DIV4);
    endcase
  end

  assign countEnd = (count_ff == halfLen - DIV_W'(1));

  // ---------------------------------------------------------------
  // counter, cleared by clear or timer mode, else frozen while advance is low
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      count_ff <= '0;
    else if (clear || mode == MODE_M_TIMER)
      count_ff <= '0;
    else if (advance)
      count_ff <= countEnd ? '0 : count_ff + DIV_W'(1);
  end

  always_comb
  begin
    if (mode == MODE_M_TIMER)
      halfTick = advance && periodTick;
    else
      halfTick = advance && countEnd;
  end

endmodule : spi_rate_gen

// ---- testbench/spi_far_end.sv ----
// far end model: slave to the port master, master to the port slave
module spi_far_end
  import spi_port_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // port pins
  input wire logic sckOut,
  input wire logic sdoOut,
  input wire logic sdoOe,
  // far pins
  output logic sckIn,
  output logic sdiIn,
  output logic slaveSelN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle_polarity_bit = 1'h0;
  logic cke = 1'h0;
  logic prevV = 1'h0;
  logic oeSeen = 1'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  wire logic v = sckOut ^ idle_polarity_bit ^ cke;

  initial
  begin
    sckIn = 1'h0;
    slaveSelN = 1'h1;
    sdiIn = 1'h0;
  end

  always @(posedge ref_clk)
  begin
    prevV <= v;
    if (v && !prevV)
    begin
      sdiIn <= sh[7];
      sh <= {sh[6:0], ~sh[0]};
    end
    if (!v && prevV)
      rx <= {rx[6:0], sdoOut};
  end

  // slave role: set clock mode and answer byte
  task automatic load(input logic p, input logic e, input logic [7:0] d);
    idle_polarity_bit = p;
    cke = e;
    repeat (3) @(posedge ref_clk);
    sh <= e ? {d[6:0], 1'h0} : d;
    sdiIn <= d[7];
  endtask : load

  task automatic xfer(input logic [7:0] d, input int n,
                      output logic [7:0] r);
    r = 8'h00;
    oeSeen = 1'h1;
    slaveSelN <= 1'h0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      sckIn <= 1'h1;
      sdiIn <= d[7 - i];
      repeat (6) @(posedge ref_clk);
      r = {r[6:0], sdoOut};
      oeSeen = oeSeen & sdoOe;
      sckIn <= 1'h0;
      repeat (6) @(posedge ref_clk);
    end
    slaveSelN <= 1'h1;
    sdiIn <= ~sdiIn;
    repeat (6) @(posedge ref_clk);
  endtask : xfer
endmodule : spi_far_end

// ---- testbench/test_spi_master_slave_port.sv ----
// self-checking bench for the serial port core
`include "spi_port_cfg.svh"
module test_spi_master_slave_port
  import spi_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, regWr, regRd, sleepMode, periodTick;
  logic [`SPI_ADDR_W-1:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic wakeReq, sckIn, sckOut, sckOe, sdiIn, sdoOut, sdoOe, slaveSelN;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 86225;
  logic [7:0] q [$];
  mode_t modes [5] = '{MODE_M_DIV4, MODE_M_DIV16, MODE_M_DIV64,
                       MODE_M_TIMER, MODE_M_RELOAD};
  int halfs [5] = '{2, 8, 32, 5, 8};

  spi_master_slave_port u_dut (.ref_clk(ref_clk), .reset(reset),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .sleepMode(sleepMode), .periodTick(periodTick),
    .wakeReq(wakeReq), .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe),
    .sdiIn(sdiIn), .sdoOut(sdoOut), .sdoOe(sdoOe), .slaveSelN(slaveSelN));

  spi_far_end u_far (.ref_clk(ref_clk), .sckOut(sckOut), .sdoOut(sdoOut),
    .sdoOe(sdoOe), .sckIn(sckIn), .sdiIn(sdiIn), .slaveSelN(slaveSelN));

  // ------------------------------
  // clock, timer tick, timeout
  // ------------------------------
  initial
  begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    periodTick <= (cycles % 5 == 4);
    if (cycles == 30000)
    begin
      bad_count++;
      summarize();
    end
  end

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic summarize();
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [`SPI_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge ref_clk);
    regWr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [`SPI_ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge ref_clk);
    regRd <= 1'h0;
    #1;
    d = regRdata;
  endtask : rd

  task automatic waitFull();
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 400 && s[0] !== 1'h1; i++)
      rd(`REG_STATUS, s);
  endtask : waitFull

  task automatic master(input int i);
    logic [7:0] tx, resp, got;
    logic last;
    int n, h;
    tx = 8'($random(seed));
    resp = 8'($random(seed));
    wr(`REG_STATUS, {1'(i == 0), i[1], 6'h00});
    wr(`REG_CTRL_ONE, {3'h1, i[0], modes[i]});
    u_far.load(i[0], i[1], resp);
    q.push_back(resp);
    wr(`REG_BUFFER, tx);
    @(posedge ref_clk) #1;
    chk({7'h00, sdoOut}, {7'h00, tx[7]});
    last = sckOut;
    for (n = 0; n < 200 && sckOut === last; n++)
      @(posedge ref_clk) #1;
    last = sckOut;
    for (h = 0; h < 200 && sckOut === last; h++)
      @(posedge ref_clk) #1;
    chk(8'(h), 8'(halfs[i]));
    if (i == 1)
    begin
      sleepMode <= 1'h1;
      repeat (2) @(posedge ref_clk) #1;
      last = sckOut;
      repeat (40) @(posedge ref_clk) #1;
      chk({7'h00, sckOut}, {7'h00, last});
      sleepMode <= 1'h0;
    end
    if (i == 2)
    begin
      wr(`REG_BUFFER, ~tx);
      rd(`REG_CTRL_ONE, got);
      chk({7'h00, got[7]}, 8'h01);
      wr(`REG_CTRL_ONE, {3'h1, i[0], modes[i]});
    end
    waitFull();
    repeat (70) @(posedge ref_clk) #1;
    chk({7'h00, sckOut}, {7'h00, i[0]});
    chk({7'h00, sckOe}, 8'h01);
    rd(`REG_BUFFER, got);
    chk(got, q.pop_front());
    chk(u_far.rx, tx);
    rd(`REG_STATUS, got);
    chk({7'h00, got[0]}, 8'h00);
  endtask : master

  task automatic slave();
    logic [7:0] d, f, r, got, prevF;
    prevF = 8'h00;
    wr(`REG_STATUS, 8'h00);
    wr(`REG_CTRL_ONE, 8'h24);
    wr(`REG_WAKE, 8'h02);
    for (int k = 0; k < 5; k++)
    begin
      d = 8'($random(seed));
      f = 8'($random(seed));
      if (k == 4)
        wr(`REG_CTRL_THREE, 8'h10);
      if (k == 1)
      begin
        u_far.xfer(~f, 3, r);
        #1;
        chk({7'h00, sdoOe}, 8'h00);
      end
      sleepMode <= (k == 0);
      wr(`REG_BUFFER, d);
      u_far.xfer(f, 8, r);
      #1;
      sleepMode <= 1'h0;
      chk({7'h00, sdoOe}, 8'h00);
      chk({7'h00, sckOe}, 8'h00);
      chk({7'h00, u_far.oeSeen}, 8'h01);
      chk(r, (k == 3) ? prevF : d);
      prevF = f;
      if (k < 2 || k == 4)
      begin
        waitFull();
        if (k == 0)
          chk({7'h00, wakeReq}, 8'h01);
        rd(`REG_BUFFER, got);
        chk(got, f);
      end
    end
  endtask : slave

  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    logic [7:0] got;
    reset = 1'h1;
    regAddr = '0;
    regWdata = 8'h00;
    regWr = 1'h0;
    regRd = 1'h0;
    sleepMode = 1'h0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'h0;
    rd(`REG_CTRL_ONE, got);
    chk(got, `RST_BYTE);
    rd(`REG_STATUS, got);
    chk(got, `RST_BYTE);
    wr(3'h7, 8'hFF);
    rd(3'h7, got);
    chk(got, 8'h00);
    wr(`REG_RELOAD, 8'h03);
    rd(`REG_RELOAD, got);
    chk(got, 8'h03);
    for (int i = 0; i < 5; i++)
      master(i);
    wr(`REG_CTRL_ONE, 8'h00);
    slave();
    summarize();
  end
endmodule : test_spi_master_slave_port
